// [dv/ahrg_conv_model.sv]
// Behavioural model of the 12-bit sampling converter seen by the glue.
// Assumes the glue drives the start, enable and byte-select pins; the
// conversion time runs in ns, free of sys_clk.
`default_nettype none

module ahrg_conv_model #(
   parameter int CONV_NS = 2000 // Conversion time, plain default
) (
   // Control pins from the glue
   input  wire logic        begin_convert_n,
   input  wire logic        outEnable_n,
   input  wire logic        byte_half_flag,
   input  wire logic        upper_half_strobe_n,
   input  wire logic        readWidthSel,
   // Bench controls: analog value and a forced second done edge
   input  wire logic [11:0] sample,
   input  wire logic        dupDone,
   // Converter outputs
   output var  logic        convDone,
   output var  logic [11:0] convData
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [11:0] value   = 12'h000; // Held conversion result
   logic [11:0] lastDrv = 12'h000; // Last value put on the bus
   logic        hiSel   = 1'b0;    // Current byte read is the high one

   initial convDone = 1'b0;

   // done ends conversion
   // Timing is in ns so the end of conversion is unrelated to sys_clk
   always @(negedge begin_convert_n) begin
      convDone = 1'b0;
      #(CONV_NS);
      value    = sample;
      convDone = 1'b1;
      // A forced extra edge lets the bench provoke an overrun
      if (dupDone) begin
         #30 convDone = 1'b0;
         #30 convDone = 1'b1;
      end
   end

   // Byte half chosen when enable falls
   always @(negedge outEnable_n) begin
      hiSel = !byte_half_flag || !upper_half_strobe_n;
   end

   // word or byte lanes
   // Released bus shows the inverse so a stale sample never matches
   always @(outEnable_n or hiSel or readWidthSel or value) begin
      if (!outEnable_n) begin
         convData = readWidthSel ? value :
                    hiSel ? {value[11:4], ~value[3:0]} : {value[3:0], ~value[7:0]};
         lastDrv  = convData;
      end else begin
         convData = ~lastDrv;
      end
   end

endmodule : ahrg_conv_model

`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the converter readout glue.
// Assumes ahrg_pkg and ahrg_readout are compiled first; drives at negedge.
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ahrg_pkg::*;

   // Stimulus
   logic sys_clk = 1'b0, rst = 1'b1, startReq = 1'b0, asyncMode = 1'b0, byteMode = 1'b0;
   logic altMode = 1'b0, waitThree = 1'b0, overrunClr = 1'b0, extTrigger = 1'b0, dupDone = 1'b0;
   logic [RES_W-1:0] sample = 12'h000;
   // Design outputs and converter pins
   logic [RES_W-1:0] result, convData;
   logic             resultValid, busy, overrun, convDone, begin_convert_n, outEnable_n;
   logic             byte_half_flag, upper_half_strobe_n, readWidthSel, io_space_strobe_n;
   logic             bus_cycle_strobe_n, hostReady, memory_acknowledge, dma_request_ch_one;
   logic [3:0]       portAddr;
   // Bookkeeping and measurements
   int               failCount = 0, compares = 0, oeN, rdyN, ackN, scN;
   logic             flagAtOe, ushAtOe, ushEnd, dmaAtOe;
   logic [RES_W-1:0] got;

   always #5 sys_clk = ~sys_clk;

   ahrg_readout uut (.sys_clk(sys_clk), .rst(rst), .startReq(startReq), .asyncMode(asyncMode),
      .byteMode(byteMode), .altMode(altMode), .waitThree(waitThree), .overrunClr(overrunClr),
      .result(result), .resultValid(resultValid), .busy(busy), .overrun(overrun),
      .extTrigger(extTrigger), .convDone(convDone), .convData(convData),
      .begin_convert_n(begin_convert_n), .outEnable_n(outEnable_n), .byte_half_flag(byte_half_flag),
      .upper_half_strobe_n(upper_half_strobe_n), .readWidthSel(readWidthSel),
      .io_space_strobe_n(io_space_strobe_n), .bus_cycle_strobe_n(bus_cycle_strobe_n),
      .portAddr(portAddr), .hostReady(hostReady), .memory_acknowledge(memory_acknowledge),
      .dma_request_ch_one(dma_request_ch_one));

   ahrg_conv_model conv (.begin_convert_n(begin_convert_n), .outEnable_n(outEnable_n),
      .byte_half_flag(byte_half_flag), .upper_half_strobe_n(upper_half_strobe_n),
      .readWidthSel(readWidthSel), .sample(sample), .dupDone(dupDone), .convDone(convDone),
      .convData(convData));

   // Verdict and end of run
   task automatic conclude();
      if (failCount == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   // Compare one value
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failCount++;
         $display("wrong value at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // A used-up bound counts as a mismatch and ends the run
   task automatic timeout();
      failCount++;
      conclude();
   endtask : timeout

   // Pulse the start request and wait for the start pulse on the pin
   task automatic kick();
      int i;
      @(negedge sys_clk) startReq = 1'b1;
      @(negedge sys_clk) startReq = 1'b0;
      for (i = 0; i < 4 && begin_convert_n !== 1'b0; i++) @(posedge sys_clk) #1;
      if (begin_convert_n !== 1'b0) timeout();
      check(portAddr, CONV_PORT);
      check({io_space_strobe_n, bus_cycle_strobe_n, busy}, 3'h1);
   endtask : kick

   // Measure pin activity until the result is complete, then until idle
   task automatic watch();
      logic prevOe, lastUsh;
      int   i, rises;
      oeN = 0; rdyN = 0; ackN = 0; scN = 0; prevOe = 1'b1; rises = 0; lastUsh = 1'b1;
      for (i = 0; i < 3000 && resultValid !== 1'b1; i++) begin
         @(posedge sys_clk) #1;
         scN += int'(begin_convert_n === 1'b0);
         oeN += int'(outEnable_n === 1'b0);
         rdyN += int'(hostReady === 1'b1);
         ackN += int'(memory_acknowledge === 1'b1);
         if (outEnable_n === 1'b0 && prevOe === 1'b1 && rises == 0) begin
            flagAtOe = byte_half_flag;
            ushAtOe  = upper_half_strobe_n;
            dmaAtOe  = dma_request_ch_one;
         end
         if (outEnable_n === 1'b1 && prevOe === 1'b0) begin
            if (rises == 0) ushEnd = lastUsh;
            rises++;
         end
         if (outEnable_n === 1'b0) lastUsh = upper_half_strobe_n;
         prevOe = outEnable_n;
      end
      if (resultValid !== 1'b1) timeout();
      got = result;
      check(dma_request_ch_one, 1'b0);
      for (i = 0; i < 100 && busy !== 1'b0; i++) @(posedge sys_clk) #1;
      if (busy !== 1'b0) timeout();
   endtask : watch

   // Let the start spacing guard run out
   task automatic rest();
      repeat (520) @(negedge sys_clk);
   endtask : rest

   // Single 12-bit read, one wait state
   task automatic t_word();
      sample = 12'hA5C;
      kick();
      watch();
      check(got, 12'hA5C);
      check(readWidthSel, 1'b1);
      check(scN, ACC_ONE_WAIT - 1);
      check(rdyN, 2 * HOST_CYC);
      check(oeN, ACC_ONE_WAIT);
      check(dmaAtOe, 1'b1);
   endtask : t_word

   // Two byte reads with the byte flag
   task automatic t_byte();
      byteMode = 1'b1;
      sample   = 12'h3C9;
      kick();
      watch();
      check(got, 12'h3C9);
      check(readWidthSel, 1'b0);
      check(flagAtOe, 1'b0);
      check(oeN, 2 * ACC_ONE_WAIT);
      check(rdyN, 3 * HOST_CYC);
      check(dmaAtOe, 1'b1);
   endtask : t_byte

   // Upper strobe arrangement, with one and then with three wait states
   task automatic t_alt();
      logic [TW-1:0] acc;
      for (int w = 0; w < 2; w++) begin
         if (w == 1) rest();
         altMode   = 1'b1;
         byteMode  = 1'b1;
         waitThree = (w == 1);
         acc       = (w == 1) ? ACC_THREE_WAIT : ACC_ONE_WAIT;
         sample    = (w == 1) ? 12'hF0E : 12'h0F1;
         kick();
         watch();
         check(got, sample);
         check(ushAtOe, 1'b0);
         check(ushEnd, 1'b1);
         check(flagAtOe, 1'b1);
         check(ackN, 2 * HOST_CYC);
         check(scN, acc - 1);
         check(oeN, 2 * acc);
      end
      altMode = 1'b0; waitThree = 1'b0; byteMode = 1'b0;
   endtask : t_alt

   // A start too soon after the last one is dropped
   task automatic t_space();
      int lowN;
      sample = 12'h001;
      kick();
      watch();
      lowN = 0;
      @(negedge sys_clk) startReq = 1'b1;
      @(negedge sys_clk) startReq = 1'b0;
      repeat (20) @(posedge sys_clk) #1 lowN += int'(begin_convert_n === 1'b0);
      check(lowN, 0);
      rest();
      sample = 12'hFFE;
      kick();
      watch();
      check(got, 12'hFFE);
   endtask : t_space

   // Start from the external trigger, off the clock edge
   task automatic t_async();
      int i;
      asyncMode = 1'b1;
      sample    = 12'h7FF;
      @(posedge sys_clk) #3 extTrigger = 1'b1;
      for (i = 0; i < 10 && begin_convert_n !== 1'b0; i++) @(posedge sys_clk) #1;
      check(begin_convert_n, 1'b0);
      watch();
      check(got, 12'h7FF);
      @(negedge sys_clk) extTrigger = 1'b0;
      asyncMode = 1'b0;
   endtask : t_async

   // A second done while the request is pending flags overrun
   task automatic t_overrun();
      dupDone = 1'b1;
      sample  = 12'h555;
      kick();
      watch();
      check(overrun, 1'b1);
      dupDone = 1'b0;
      @(negedge sys_clk) overrunClr = 1'b1;
      @(negedge sys_clk) overrunClr = 1'b0;
      @(posedge sys_clk) #1;
      check(overrun, 1'b0);
   endtask : t_overrun

   // Main sequence: reset for 4 cycles, then each scenario apart
   initial begin
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      t_word();
      rest();
      t_byte();
      rest();
      t_alt();
      rest();
      t_space();
      rest();
      t_async();
      rest();
      t_overrun();
      conclude();
   end

endmodule : testbench

`default_nettype wire

// [hw/ahrg_pkg.sv]
// Constants shared by the converter readout host glue.
// Assumes a 100 MHz host clock; all pin timing derives from it.
`default_nettype none

package ahrg_pkg;

   // Clock period of sys_clk
   localparam int CLK_PERIOD_NS    = 10;
   // One processor bus cycle on the converter side
   localparam int HOST_CYCLE_NS    = 80;
   // Least spacing between two start pulses
   localparam int START_SPACING_NS = 5000;
   // Port address that the converter answers on, for start and read
   localparam logic [3:0] CONV_PORT = 4'h8;

   // Timer width; every count below fits
   localparam int TW = 10;
   // One host cycle in clocks, rounded up as a least time
   localparam logic [TW-1:0] HOST_CYC =
      TW'((HOST_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Access with one wait state: two host cycles
   localparam logic [TW-1:0] ACC_ONE_WAIT = TW'(2 * int'(HOST_CYC));
   // Access with three wait states: four host cycles
   localparam logic [TW-1:0] ACC_THREE_WAIT = TW'(4 * int'(HOST_CYC));
   // Start spacing in clocks, rounded up
   localparam logic [TW-1:0] START_SPACING =
      TW'((START_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Result width and byte split (8 + 4)
   localparam int RES_W  = 12;
   localparam int HI_W   = 8;
   localparam int LO_W   = 4;

   // Sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_START = 8'h02,
      ST_WAIT  = 8'h04,
      ST_PREP  = 8'h08,
      ST_RDHI  = 8'h10,
      ST_MID   = 8'h20,
      ST_RDLO  = 8'h40,
      ST_NOP   = 8'h80
   } ahrg_state_t;

endpackage : ahrg_pkg

`default_nettype wire

// [hw/ahrg_readout.sv]
// Host-side glue that starts conversions on a 12-bit sampling converter
// and reads back its result as one word or as two bytes with wait states.
// Assumes the converter pins reach this block unsynchronised; sys_clk 100 MHz.
//
// Overview of operation
// - Start conversion by write to converter port
// - Read status and result at same port
// - Ready generated to add one wait state
// - One idle host cycle after each read
// - Conversion done raises DMA request one
// - Result read clears the request latch
// - Request serviced before next conversion completes
// - On done, byte flag low, then high read
// - Read decode drives active-low output enable
// - Each byte read spans two host cycles
// - Flag high, then low byte read likewise
// - Alternate mode asserts upper strobe before reading
// - Alternate mode acknowledge gives one-cycle wait
// - Upper strobe released during high read
// - Three wait states supported on request
// - Start pulses spaced at least five microseconds
`default_nettype none

module ahrg_readout (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   // User controls
   input  wire logic                      startReq,
   input  wire logic                      asyncMode,
   input  wire logic                      byteMode,
   input  wire logic                      altMode,
   input  wire logic                      waitThree,
   input  wire logic                      overrunClr,
   // User results
   output logic [ahrg_pkg::RES_W-1:0]     result,
   output logic                           resultValid,
   output logic                           busy,
   output logic                           overrun,
   // Converter pins, inputs
   input  wire logic                      extTrigger,
   input  wire logic                      convDone,
   input  wire logic [ahrg_pkg::RES_W-1:0] convData,
   // Converter pins, outputs
   output logic                           begin_convert_n,
   output logic                           outEnable_n,
   output logic                           byte_half_flag,
   output logic                           upper_half_strobe_n,
   output logic                           readWidthSel,
   output logic                           io_space_strobe_n,
   output logic                           bus_cycle_strobe_n,
   output logic [3:0]                     portAddr,
   output logic                           hostReady,
   output logic                           memory_acknowledge,
   output logic                           dma_request_ch_one
);
   import ahrg_pkg::*;

   // Synchronised pin inputs
   logic [1:0]        ctlSync;      // {trigger, done} after two flops
   logic [RES_W-1:0]  dataSync;     // Data bus after two flops
   logic              trigPrev_q;   // Edge detect history
   logic              donePrev_q;
   logic              trigRise;
   logic              doneRise;
   // Sequencer
   ahrg_state_t       state_q;
   ahrg_state_t       state_d;
   logic              stateLoad;    // Entering a new state
   logic [TW-1:0]     stateVal;     // Duration of the state entered
   logic [TW-1:0]     stCount;
   logic              stDone;
   logic [TW-1:0]     accLen;       // Access length with wait states
   logic              lastHostCyc;  // Final host cycle of an access
   logic              readyWin;     // Ready window, one clock ahead
   // Start spacing guard
   logic              guardLoad;
   logic [TW-1:0]     guardCount;
   logic              guardDone;
   // Bookkeeping
   logic              doneSeen_q;   // Done seen for current conversion
   logic              startEvt;
   logic              readEnd;      // Final clock of the final read
   logic [RES_W-1:0]  result_d;
   // Pin next values
   logic              isRead_d;
   logic              strobe_d;
   // Converter pins cross into sys_clk before anything looks at them
   ahrg_sync #(.W(2)) u_ctl_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .asyncIn ({extTrigger, convDone}),
      .syncOut (ctlSync)
   );

   // Data is held stable by the converter for the whole enable window
   ahrg_sync #(.W(RES_W)) u_data_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .asyncIn (convData),
      .syncOut (dataSync)
   );

   // Edge history on the synchronised controls
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         trigPrev_q <= 1'b0;
         donePrev_q <= 1'b0;
      end else begin
         trigPrev_q <= ctlSync[1];
         donePrev_q <= ctlSync[0];
      end
   end

   assign trigRise = ctlSync[1] && !trigPrev_q;
   assign doneRise = ctlSync[0] && !donePrev_q;
   assign startEvt = asyncMode ? trigRise : startReq;
   assign accLen = waitThree ? ACC_THREE_WAIT : ACC_ONE_WAIT;
   // State duration timer
   ahrg_timer #(.W(TW)) u_state_tmr (
      .sys_clk (sys_clk),
      .rst     (rst),
      .load    (stateLoad),
      .loadVal (stateVal),
      .count   (stCount),
      .done    (stDone)
   );
   ahrg_timer #(.W(TW)) u_guard_tmr (
      .sys_clk (sys_clk),
      .rst     (rst),
      .load    (guardLoad),
      .loadVal (START_SPACING - TW'(1)),
      .count   (guardCount),
      .done    (guardDone)
   );

   // Next state; a start that comes during the guard is simply dropped
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (startEvt && guardDone) state_d = ST_START;
         end
         ST_START: begin
            if (stDone) state_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (doneSeen_q) state_d = byteMode ? ST_PREP : ST_RDHI;
         end
         ST_PREP: begin
            if (stDone) state_d = ST_RDHI;
         end
         ST_RDHI: begin
            if (stDone) state_d = byteMode ? ST_MID : ST_NOP;
         end
         ST_MID: begin
            if (stDone) state_d = ST_RDLO;
         end
         ST_RDLO: begin
            if (stDone) state_d = ST_NOP;
         end
         // idle host cycle after a read
         ST_NOP: begin
            if (stDone) state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   assign stateLoad = (state_d != state_q);
   assign guardLoad = stateLoad && (state_d == ST_START);
   assign stateVal = ((state_d == ST_START) || (state_d == ST_RDHI) || (state_d == ST_RDLO))
                   ? accLen - TW'(1) : HOST_CYC - TW'(1);
   assign lastHostCyc = (stCount < HOST_CYC);
   assign readyWin    = (stCount <= HOST_CYC);  // Registered ready then spans the whole last host cycle
   assign readEnd     = stDone && ((state_q == ST_RDLO) || (state_q == ST_RDHI && !byteMode));
   assign result_d = (state_q == ST_RDHI && byteMode) ? {dataSync[RES_W-1 -: HI_W], result[LO_W-1:0]}
                   : (state_q == ST_RDLO) ? {result[RES_W-1 -: HI_W], dataSync[RES_W-1 -: LO_W]}
                   : dataSync;
   assign isRead_d = (state_d == ST_RDHI) || (state_d == ST_RDLO);
   assign strobe_d = isRead_d || (state_d == ST_START);
   // State register
   always_ff @(posedge sys_clk) begin
      if (rst) state_q <= ST_IDLE;
      else     state_q <= state_d;
   end
   // Done latch; a new done beats the clear at start
   always_ff @(posedge sys_clk) begin
      if (rst)                   doneSeen_q <= 1'b0;
      else if (doneRise)         doneSeen_q <= 1'b1;
      else if (state_d == ST_START) doneSeen_q <= 1'b0;
   end
   // Result capture on the last clock of each read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         result      <= '0;
         resultValid <= 1'b0;
      end else begin
         if (stDone && (state_q == ST_RDHI || state_q == ST_RDLO)) result <= result_d;
         resultValid <= readEnd;
      end
   end
   // request latch, cleared by read; a new done wins
   always_ff @(posedge sys_clk) begin
      if (rst)           dma_request_ch_one <= 1'b0;
      else if (doneRise) dma_request_ch_one <= 1'b1;
      else if (readEnd)  dma_request_ch_one <= 1'b0;
   end
   always_ff @(posedge sys_clk) begin
      if (rst)                                   overrun <= 1'b0;
      else if (doneRise && dma_request_ch_one)   overrun <= 1'b1;
      else if (overrunClr)                       overrun <= 1'b0;
   end

   // Pin outputs, registered from next-state decode; readWidthSel registered from byteMode
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         begin_convert_n     <= 1'b1;
         outEnable_n         <= 1'b1;
         io_space_strobe_n   <= 1'b1;
         bus_cycle_strobe_n  <= 1'b1;
         portAddr            <= 4'h0;
         readWidthSel        <= 1'b1;
         busy                <= 1'b0;
      end else begin
         begin_convert_n     <= !(state_d == ST_START);
         outEnable_n         <= !isRead_d;
         io_space_strobe_n   <= !strobe_d;
         bus_cycle_strobe_n  <= !strobe_d;
         portAddr            <= strobe_d ? CONV_PORT : 4'h0;
         readWidthSel        <= !byteMode;
         busy                <= (state_d != ST_IDLE);
      end
   end

   // Byte select and upper strobe; idle level is high for both
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         byte_half_flag      <= 1'b1;
         upper_half_strobe_n <= 1'b1;
      end else begin
         // low for high byte, high for low byte; held high throughout in alternate mode
         byte_half_flag      <= altMode || !((state_d == ST_PREP) || (state_d == ST_RDHI));
         upper_half_strobe_n <= !(altMode && byteMode && ((state_d == ST_PREP) ||
                                 (state_d == ST_RDHI && !(state_q == ST_RDHI && lastHostCyc))));
      end
   end

   // ready, acknowledge in final host cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hostReady          <= 1'b0;
         memory_acknowledge <= 1'b0;
      end else begin
         hostReady          <= strobe_d && (state_d == state_q) && readyWin;
         memory_acknowledge <= altMode && isRead_d && (state_d == state_q) && readyWin;
      end
   end

   // Assertions on the host side of the link; one clock domain, off in reset
   default clocking cb_sys @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_start_port;
      !begin_convert_n |-> (portAddr == CONV_PORT) && !io_space_strobe_n;
   endproperty
   a_start_port: assert property (p_start_port) else $error("start without port write");
   property p_read_port;
      !outEnable_n |-> (portAddr == CONV_PORT) && !bus_cycle_strobe_n;
   endproperty
   a_read_port: assert property (p_read_port) else $error("read not at converter port");
   property p_ready_wait;
      $fell(outEnable_n) |-> !hostReady [*8];
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("ready came without wait state");
   property p_nop_gap;
      $rose(outEnable_n) |-> outEnable_n [*8];
   endproperty
   a_nop_gap: assert property (p_nop_gap) else $error("access too soon after read");
   property p_dma_set;
      doneRise |=> dma_request_ch_one;
   endproperty
   a_dma_set: assert property (p_dma_set) else $error("done did not raise request");
   property p_dma_clear;
      readEnd && !doneRise |=> !dma_request_ch_one && resultValid;
   endproperty
   a_dma_clear: assert property (p_dma_clear) else $error("read did not clear request");
   property p_overrun;
      doneRise && dma_request_ch_one |=> overrun;
   endproperty
   a_overrun: assert property (p_overrun) else $error("lost result not flagged");
   property p_flag_low;
      (state_q == ST_WAIT) && doneSeen_q && byteMode && !altMode |=> !byte_half_flag ##8 !outEnable_n;
   endproperty
   a_flag_low: assert property (p_flag_low) else $error("high byte read not after flag low");
   property p_read_len;
      $fell(outEnable_n) && !waitThree |-> !outEnable_n [*8] ##1 !outEnable_n [*8] ##1 outEnable_n;
   endproperty
   a_read_len: assert property (p_read_len) else $error("byte read not two host cycles");
   property p_flag_high;
      !outEnable_n && (state_q == ST_RDLO) && !altMode |-> byte_half_flag;
   endproperty
   a_flag_high: assert property (p_flag_high) else $error("low byte read with flag low");
   property p_strobe_release;
      $fell(outEnable_n) && altMode && byteMode && (state_q == ST_RDHI) && !waitThree
         |-> !upper_half_strobe_n ##[1:9] upper_half_strobe_n;
   endproperty
   a_strobe_release: assert property (p_strobe_release) else $error("upper strobe held through read");
   property p_spacing;
      $fell(begin_convert_n) |-> guardCount == (START_SPACING - TW'(1));
   endproperty
   a_spacing: assert property (p_spacing) else $error("start pulses too close");
   property p_no_early_read;
      !outEnable_n |-> doneSeen_q;
   endproperty
   a_no_early_read: assert property (p_no_early_read) else $error("read before conversion done");

endmodule : ahrg_readout

`default_nettype wire

// [hw/ahrg_sync.sv]
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to sys_clk; bits are not coherent.
`default_nettype none

module ahrg_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // Asynchronous input and its synchronised copy
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);

   logic [W-1:0] meta_q;   // First stage, read only by the second

   // Two flops in series; a multi-bit bus is only safe when held stable
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_q  <= '0;
         syncOut <= '0;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule : ahrg_sync

`default_nettype wire

// [hw/ahrg_timer.sv]
// Loadable down-counter used for pin timing and start spacing.
// Assumes load value is count-1 so that N cycles elapse before done.
`default_nettype none

module ahrg_timer #(
   parameter int W = 10
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // Load strobe and value
   input  wire logic         load,
   input  wire logic [W-1:0] loadVal,
   // Current count and expiry
   output logic      [W-1:0] count,
   output logic              done
);

   // Expired once zero is reached; a reload does not mask it, which keeps
   // the caller's next-state logic free of a loop through this output
   assign done = (count == '0);

   // Count down to zero and hold there
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count <= '0;
      end else if (load) begin
         count <= loadVal;
      end else if (count != '0) begin
         count <= count - W'(1);
      end
   end

endmodule : ahrg_timer

`default_nettype wire
